// *** hpp_defs.svh ***
// Constants for the host parallel port: address map, field positions, timing counts.
// Included by the package and both ends; no logic of its own.
`ifndef HPP_DEFS_SVH
`define HPP_DEFS_SVH

`define HPP_ADDR_W        19
`define HPP_DATA_W        32
`define HPP_REG_WORDS     16
// Valid address window: byte address, word index and byte offset together, below this bound
`define HPP_VALID_LIMIT   19'h0_0040
`define HPP_STATUS_ADDR   19'h0_003C
// Size codes of strobe-style 32-bit mode
`define HPP_SIZ_LONG      2'b00
`define HPP_SIZ_BYTE      2'b01
`define HPP_SIZ_WORD      2'b10
`define HPP_SIZ_TRIPLE    2'b11
// Cycles the device holds wait low before acknowledging
`define HPP_WAIT_CYC      2
// Host controller timing in clk_sys cycles
`define HPP_SETUP_CYC     1
`define HPP_TIMEOUT_CYC   16
`define HPP_CMD_ADDR      8'h00
`define HPP_CMD_WDATA     8'h04
`define HPP_CMD_CTRL      8'h08
`define HPP_CMD_STAT      8'h0C
`define HPP_CMD_RDATA     8'h10

`endif

// *** hpp_pkg.sv ***
// Types shared by both ends of the host parallel port.
// Assumes hpp_defs.svh is on the include path.
`include "hpp_defs.svh"
package hpp_pkg;
  typedef logic [`HPP_ADDR_W-1:0] hpp_addr_t;
  typedef logic [`HPP_DATA_W-1:0] hpp_data_t;
  typedef enum logic {HPP_STROBE_STYLE, HPP_LANE_STYLE} hpp_style_e;
endpackage : hpp_pkg

// *** hpp_if.sv ***
// Pin bundle between the host controller and the device port.
// Resolves the open-drain levels from the enables with pull-up assigns of its own.
`timescale 1ns/100ps
interface hpp_if;
  logic        chip_select_n;
  logic        data_strobe_n;
  logic        read_not_write;
  logic [1:0]  size_or_lane_select;
  logic [18:0] host_addr_lines;
  logic [31:0] host_data_lines_h;
  logic [31:0] host_data_lines_d;
  logic        data_oe_h_n;
  logic        data_oe_d_n;
  logic        transfer_ack_n_out;
  logic        transfer_ack_n_oe_n;
  logic        wait_n_out;
  logic        wait_n_oe_n;
  logic        bus_fault_n_out;
  logic        bus_fault_n_oe_n;
  logic        bus_style_select;
  logic        half_width_select;
  logic        device_reset_n;
  // Pull-up resolution of the three open-drain answers
  logic        transfer_ack_n;
  logic        wait_n;
  logic        bus_fault_n;
  logic [31:0] host_data_lines;
  assign transfer_ack_n  = transfer_ack_n_oe_n ? 1'b1 : transfer_ack_n_out;
  assign wait_n          = wait_n_oe_n ? 1'b1 : wait_n_out;
  assign bus_fault_n     = bus_fault_n_oe_n ? 1'b1 : bus_fault_n_out;
  assign host_data_lines = !data_oe_d_n ? host_data_lines_d :
                           !data_oe_h_n ? host_data_lines_h : 32'h0000_0000;
  modport host (
    output chip_select_n, data_strobe_n, read_not_write, size_or_lane_select,
    output host_addr_lines, host_data_lines_h, data_oe_h_n,
    output bus_style_select, half_width_select, device_reset_n,
    input  host_data_lines, transfer_ack_n, wait_n, bus_fault_n
  );
  modport device (
    input  chip_select_n, data_strobe_n, read_not_write, size_or_lane_select,
    input  host_addr_lines, host_data_lines, bus_style_select, half_width_select,
    input  device_reset_n,
    output host_data_lines_d, data_oe_d_n,
    output transfer_ack_n_out, transfer_ack_n_oe_n, wait_n_out, wait_n_oe_n,
    output bus_fault_n_out, bus_fault_n_oe_n
  );
endinterface : hpp_if

// *** hpp_device.sv ***
// Device end of the host parallel port: register file reached by the host pins.
// Assumes pins arrive asynchronously; all are synchronised to clk_sys.
//
// Overview of operation
// - Access only while select and strobe low
// - Direction high reads, low writes; drive on reads
// - Acknowledge low on completion, else released
// - Bus fault low on unmapped address
// - Strobe style: fault suppresses acknowledge
// - Lane style: acknowledge despite fault
// - Wait low while transfer cannot complete
// - Style pin: low strobe style, high lane style
// - Half width ignores upper sixteen data lines
// - 19-bit address; half width ignores bit zero
// - Strobe 32-bit: size inputs give transfer size
// - Strobe 16-bit: size inputs are byte strobes
// - Lane style: size inputs enable lanes 0,1
// - Lane 32-bit: address bits 1,0 enable lanes 3,2
// - Reset pin asynchronous, low holds reset
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "hpp_defs.svh"
module hpp_device
  import hpp_pkg::*;
#(
  parameter int WAIT_CYC = `HPP_WAIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Pins
  hpp_if.device            pins,
  // User side
  output      logic [31:0] status_word,
  output      logic        access_seen
);
  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [4:0]  ctl_s1, ctl_s2;
  logic [1:0]  siz_s1, siz_s2;
  hpp_addr_t   adr_s1, adr_s2;
  hpp_data_t   dat_s1, dat_s2;
  logic        rst_s1, rst_s2;
  logic        rst_in_n;
  logic        rst_n;
  assign rst_in_n = resetn & pins.device_reset_n;
  assign rst_n    = rst_s2;
  // Pin reset is asynchronous on assertion, released through two flops
  always_ff @(posedge clk_sys or negedge rst_in_n) begin
    if (!rst_in_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_s1 <= 5'h03;
      ctl_s2 <= 5'h03;
      siz_s1 <= 2'b11;
      siz_s2 <= 2'b11;
      adr_s1 <= '0;
      adr_s2 <= '0;
      dat_s1 <= '0;
      dat_s2 <= '0;
    end else begin
      ctl_s1 <= {pins.read_not_write, pins.half_width_select, pins.bus_style_select,
                 pins.data_strobe_n, pins.chip_select_n};
      ctl_s2 <= ctl_s1;
      siz_s1 <= pins.size_or_lane_select;
      siz_s2 <= siz_s1;
      adr_s1 <= pins.host_addr_lines;
      adr_s2 <= adr_s1;
      dat_s1 <= pins.host_data_lines;
      dat_s2 <= dat_s1;
    end
  end
  logic       cs_n, ds_n, half, lane_style, active, rnw;
  assign rnw        = ctl_s2[4];
  assign cs_n       = ctl_s2[0];
  assign ds_n       = ctl_s2[1];
  assign lane_style = ctl_s2[2];
  assign half       = ctl_s2[3];
  assign active     = !cs_n && !ds_n;

  // ---------------------------------------------------------------
  // Address and lane decode
  // ---------------------------------------------------------------
  hpp_addr_t  eff_addr;
  logic [3:0] lanes;
  logic       mapped;
  always_comb begin
    eff_addr = adr_s2;
    lanes    = 4'hF;
    if (half) begin
      eff_addr[0] = 1'b0;
      if (lane_style) lanes = {2'b00, ~siz_s2[1], ~siz_s2[0]};
      else lanes = {2'b00, ~siz_s2[1], ~siz_s2[0]};
    end else if (lane_style) begin
      lanes       = {~adr_s2[1], ~adr_s2[0], ~siz_s2[1], ~siz_s2[0]};
      eff_addr[1:0] = 2'b00;
    end else begin
      // Little-endian style size code from the byte offset
      if (siz_s2 == `HPP_SIZ_BYTE) lanes = 4'b0001 << adr_s2[1:0];
      else if (siz_s2 == `HPP_SIZ_WORD) lanes = adr_s2[1] ? 4'b1100 : 4'b0011;
      else if (siz_s2 == `HPP_SIZ_TRIPLE) lanes = 4'b0111;
      else lanes = 4'b1111;
      eff_addr[1:0] = 2'b00;
    end
  end
  assign mapped = eff_addr < `HPP_VALID_LIMIT;

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {HPP_IDLE, HPP_HOLD, HPP_DONE} hpp_dev_state_e;
  hpp_dev_state_e state;
  logic [1:0]     wcnt;
  logic [31:0]    regs [`HPP_REG_WORDS];
  logic [3:0]     widx;
  logic [31:0]    rdat;
  logic           fault;
  assign widx = eff_addr[5:2];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= HPP_IDLE;
      wcnt  <= 2'd0;
      fault <= 1'b0;
    end else begin
      case (state)
        HPP_IDLE: begin
          if (active) begin
            state <= HPP_HOLD;
            wcnt  <= 2'd0;
            fault <= !mapped;
          end
        end
        HPP_HOLD: begin
          if (!active) state <= HPP_IDLE;
          else if (wcnt == 2'(WAIT_CYC - 1)) state <= HPP_DONE;
          else wcnt <= wcnt + 2'd1;
        end
        HPP_DONE: begin
          if (!active) state <= HPP_IDLE;
        end
        default: state <= HPP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register file and read data
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `HPP_REG_WORDS; i++) regs[i] <= 32'h0000_0000;
    end else if (state == HPP_HOLD && active && wcnt == 2'(WAIT_CYC - 1)
                 && !rnw && mapped && widx != 4'hF) begin
      for (int b = 0; b < 4; b++) begin
        if (lanes[b]) regs[widx][8*b +: 8] <= dat_s2[8*b +: 8];
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdat <= 32'h0000_0000;
    end else if (state == HPP_HOLD) begin
      // Top word reads back the live port status
      if (widx == 4'hF) rdat <= status_word;
      else rdat <= regs[widx];
    end
  end
  assign status_word = {26'h000_0000, half, lane_style, fault, 1'b0,
                        state == HPP_DONE, active};
  assign access_seen = state == HPP_DONE;

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic answering;
  assign answering = active && state != HPP_IDLE;
  assign pins.host_data_lines_d  = half ? {16'h0000, rdat[15:0]} : rdat;
  assign pins.data_oe_d_n        = !(answering && rnw);
  assign pins.wait_n_out          = 1'b0;
  assign pins.wait_n_oe_n         = !(active && state == HPP_HOLD);
  assign pins.bus_fault_n_out     = 1'b0;
  assign pins.bus_fault_n_oe_n    = !(answering && state == HPP_DONE && fault);
  assign pins.transfer_ack_n_out  = 1'b0;
  // Lane style acks regardless; strobe style withholds on fault
  assign pins.transfer_ack_n_oe_n = !(answering && state == HPP_DONE
                                      && (lane_style || !fault));
endmodule : hpp_device

// *** hpp_host.sv ***
// Host controller end: turns command-port orders into pin cycles.
// Assumes the device answers within the timeout; otherwise flags it.
`timescale 1ns/100ps
`include "hpp_defs.svh"
module hpp_host
  import hpp_pkg::*;
#(
  parameter int TIMEOUT_CYC = `HPP_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Command port
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  output      logic [31:0] cmd_rdata,
  // Pins
  hpp_if.host              pins
);
  // ---------------------------------------------------------------
  // Command registers
  // ---------------------------------------------------------------
  logic [18:0] addr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [5:0]  ctrl_r;   // 0 in place of go, rnw, siz[1:0], style, half
  logic        busy, fault_seen, timeout_seen, done_seen;
  logic        go;
  assign go = cmd_write && cmd_addr == `HPP_CMD_CTRL && cmd_wdata[5] && !busy;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      addr_r  <= 19'h0_0000;
      wdata_r <= 32'h0000_0000;
      ctrl_r  <= 6'h03;
    end else if (cmd_write) begin
      if (cmd_addr == `HPP_CMD_ADDR) addr_r <= cmd_wdata[18:0];
      else if (cmd_addr == `HPP_CMD_WDATA) wdata_r <= cmd_wdata;
      else if (cmd_addr == `HPP_CMD_CTRL) ctrl_r <= {1'b0, cmd_wdata[4:0]};
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) cmd_rdata <= 32'h0000_0000;
    else if (cmd_read) begin
      if (cmd_addr == `HPP_CMD_ADDR) cmd_rdata <= {13'h0000, addr_r};
      else if (cmd_addr == `HPP_CMD_WDATA) cmd_rdata <= wdata_r;
      else if (cmd_addr == `HPP_CMD_CTRL) cmd_rdata <= {27'h000_0000, ctrl_r[4:0]};
      else if (cmd_addr == `HPP_CMD_STAT)
        cmd_rdata <= {28'h000_0000, timeout_seen, fault_seen, done_seen, busy};
      else if (cmd_addr == `HPP_CMD_RDATA) cmd_rdata <= rdata_r;
      else cmd_rdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Pin sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {HH_IDLE, HH_SETUP, HH_STROBE, HH_END} hpp_host_state_e;
  hpp_host_state_e state;
  logic [4:0] tcnt;
  logic       ack_s1, ack_s2, flt_s1, flt_s2;
  logic [31:0] dat_s1, dat_s2;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      flt_s1 <= 1'b1;
      flt_s2 <= 1'b1;
      dat_s1 <= 32'h0000_0000;
      dat_s2 <= 32'h0000_0000;
    end else begin
      ack_s1 <= pins.transfer_ack_n;
      ack_s2 <= ack_s1;
      flt_s1 <= pins.bus_fault_n;
      flt_s2 <= flt_s1;
      dat_s1 <= pins.host_data_lines;
      dat_s2 <= dat_s1;
    end
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state        <= HH_IDLE;
      tcnt         <= 5'd0;
      busy         <= 1'b0;
      done_seen    <= 1'b0;
      fault_seen   <= 1'b0;
      timeout_seen <= 1'b0;
      rdata_r      <= 32'h0000_0000;
    end else begin
      case (state)
        HH_IDLE: begin
          if (go) begin
            state        <= HH_SETUP;
            busy         <= 1'b1;
            done_seen    <= 1'b0;
            fault_seen   <= 1'b0;
            timeout_seen <= 1'b0;
            tcnt         <= 5'd0;
          end
        end
        HH_SETUP: state <= HH_STROBE;
        HH_STROBE: begin
          tcnt <= tcnt + 5'd1;
          if (!ack_s2 || !flt_s2) begin
            state      <= HH_END;
            done_seen  <= !ack_s2;
            fault_seen <= !flt_s2;
            // Upper lines ignored in half width
            if (ctrl_r[4]) rdata_r <= ctrl_r[0] ? {16'h0000, dat_s2[15:0]} : dat_s2;
          end else if (tcnt == 5'(TIMEOUT_CYC - 1)) begin
            state        <= HH_END;
            timeout_seen <= 1'b1;
          end
        end
        HH_END: begin
          // Wait for the device to release before a new cycle
          if (ack_s2 && flt_s2) begin
            state <= HH_IDLE;
            busy  <= 1'b0;
          end
        end
        default: state <= HH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic cycle_on;
  assign cycle_on = state == HH_SETUP || state == HH_STROBE;
  assign pins.chip_select_n       = !cycle_on;
  assign pins.data_strobe_n       = state != HH_STROBE;
  assign pins.read_not_write      = ctrl_r[4];
  assign pins.size_or_lane_select = ctrl_r[3:2];
  // Half width holds A0 and the upper data lines at zero
  assign pins.host_addr_lines     = ctrl_r[0] ? {addr_r[18:1], 1'b0} : addr_r;
  assign pins.host_data_lines_h   = ctrl_r[0] ? {16'h0000, wdata_r[15:0]} : wdata_r;
  assign pins.data_oe_h_n         = !(cycle_on && !ctrl_r[4]);
  assign pins.bus_style_select    = ctrl_r[1];
  assign pins.half_width_select   = ctrl_r[0];
  assign pins.device_reset_n      = resetn;
endmodule : hpp_host

// *** hpp_props.sv ***
// Checker for the pins joining host and device ends of the parallel port.
// Assumes it watches the resolved open-drain levels of the interface.
`timescale 1ns/100ps
module hpp_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Host side pins
  input wire logic        chip_select_n,
  input wire logic        data_strobe_n,
  input wire logic        read_not_write,
  input wire logic [18:0] host_addr_lines,
  input wire logic        bus_style_select,
  input wire logic        device_reset_n,
  // Device answers
  input wire logic        data_oe_d_n,
  input wire logic        transfer_ack_n,
  input wire logic        wait_n,
  input wire logic        bus_fault_n,
  input wire logic        transfer_ack_n_oe_n,
  input wire logic        wait_n_oe_n,
  input wire logic        bus_fault_n_oe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // --------------------------------
  // Assertions
  // --------------------------------
  ack_in_access_a: assert property ($fell(transfer_ack_n) |-> !chip_select_n && !data_strobe_n)
    else $error("acknowledge outside an access");
  write_no_drive_a: assert property (!read_not_write [*4] |-> data_oe_d_n)
    else $error("device drives data during write");
  answer_bound_a: assert property ($fell(data_strobe_n) && !chip_select_n
    |-> ##[2:10] (!transfer_ack_n || !bus_fault_n)) else $error("no answer to access");
  fault_addr_a: assert property ($fell(bus_fault_n) |-> host_addr_lines >= 19'h0_0040)
    else $error("fault on mapped address");
  fault_no_ack_a: assert property (!bus_style_select && !bus_fault_n |-> transfer_ack_n)
    else $error("acknowledge with fault in strobe style");
  lane_ack_a: assert property (bus_style_select && $fell(bus_fault_n)
    |-> ##[0:2] !transfer_ack_n) else $error("lane style fault without acknowledge");
  wait_then_ack_a: assert property ($fell(wait_n) |-> ##[1:4] (!transfer_ack_n || !bus_fault_n))
    else $error("wait not followed by answer");
  reset_quiet_a: assert property ($rose(device_reset_n)
    |-> transfer_ack_n_oe_n && wait_n_oe_n && bus_fault_n_oe_n) else $error("answer in reset");
  release_ends_a: assert property ($rose(data_strobe_n)
    |-> ##[1:5] (transfer_ack_n_oe_n && wait_n_oe_n && bus_fault_n_oe_n))
    else $error("answers not released");
  // Main scenarios
  c_lane_fault: cover property (bus_style_select && !bus_fault_n && !transfer_ack_n);
  c_strobe_fault: cover property (!bus_style_select && !bus_fault_n);
  c_read_ack: cover property (read_not_write && !transfer_ack_n);
endmodule : hpp_props

// *** host_parallel_port_with_bus_modes_tb.sv ***
// Testbench: host end and device end joined through the pin interface.
// Assumes command offsets and control layout of the host end.
`timescale 1ns/100ps
`include "hpp_defs.svh"
module host_parallel_port_with_bus_modes_tb;
  import hpp_pkg::*;
  logic        clk_sys, resetn, cmd_write, cmd_read, sty;
  logic        access_seen;
  logic        seen_q = 1'b0;
  logic [7:0]  cmd_addr;
  logic [31:0] cmd_wdata, cmd_rdata, v, d, s, w, x, sw;
  int          n_seen = 0;
  int          n_xfer = 0;
  logic [18:0] a;
  logic [3:0]  en;
  int          failures, n_compared;
  hpp_if hpp_if_i ();
  hpp_host hpp_host_i (.clk_sys(clk_sys), .resetn(resetn), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_rdata(cmd_rdata), .pins(hpp_if_i));
  hpp_device hpp_device_i (.clk_sys(clk_sys), .resetn(resetn), .pins(hpp_if_i),
    .status_word(sw), .access_seen(access_seen));
  // Each completed access shows one rising edge of access_seen
  always @(posedge clk_sys) begin
    seen_q <= access_seen;
    if (access_seen === 1'b1 && seen_q !== 1'b1) n_seen <= n_seen + 1;
  end
  hpp_props hpp_props_i (.clk_sys(clk_sys), .resetn(resetn),
    .chip_select_n(hpp_if_i.chip_select_n), .data_strobe_n(hpp_if_i.data_strobe_n),
    .read_not_write(hpp_if_i.read_not_write), .host_addr_lines(hpp_if_i.host_addr_lines),
    .bus_style_select(hpp_if_i.bus_style_select), .device_reset_n(hpp_if_i.device_reset_n),
    .data_oe_d_n(hpp_if_i.data_oe_d_n), .transfer_ack_n(hpp_if_i.transfer_ack_n),
    .wait_n(hpp_if_i.wait_n), .bus_fault_n(hpp_if_i.bus_fault_n),
    .transfer_ack_n_oe_n(hpp_if_i.transfer_ack_n_oe_n),
    .wait_n_oe_n(hpp_if_i.wait_n_oe_n), .bus_fault_n_oe_n(hpp_if_i.bus_fault_n_oe_n));
  // --------------------------------
  // Tasks and expectations
  // --------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] val);
    @(posedge clk_sys);
    cmd_addr  <= ad;
    cmd_wdata <= val;
    cmd_write <= 1'b1;
    @(posedge clk_sys);
    cmd_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] val);
    @(posedge clk_sys);
    cmd_addr <= ad;
    cmd_read <= 1'b1;
    @(posedge clk_sys);
    cmd_read <= 1'b0;
    #1 val = cmd_rdata;
  endtask : rd
  // Control word: go, direction, size, style, half width
  function automatic logic [31:0] ctl(input logic rnw, input logic [1:0] sz,
                                       input logic st, input logic hf);
    return {26'h0, 1'b1, rnw, sz, st, hf};
  endfunction : ctl
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] en_n);
    for (int k = 0; k < 4; k++) begin
      if (!en_n[k]) o[8*k +: 8] = n[8*k +: 8];
    end
    return o;
  endfunction : merge
  // Lanes written by a strobe-style 32-bit access, by size code and byte offset
  function automatic logic [3:0] size_lanes(input logic [1:0] sz, input logic [1:0] off);
    if (sz == `HPP_SIZ_BYTE) return 4'b0001 << off;
    else if (sz == `HPP_SIZ_WORD) return off[1] ? 4'b1100 : 4'b0011;
    else if (sz == `HPP_SIZ_TRIPLE) return 4'b0111;
    else return 4'b1111;
  endfunction : size_lanes
  // Polling is bounded so a lost answer cannot hang the run
  task automatic xfer(input logic [18:0] ad, input logic [31:0] val, input logic [31:0] c,
                      output logic [31:0] st, output logic [31:0] r);
    wr(8'h00, {13'h0, ad});
    wr(8'h04, val);
    wr(8'h08, c);
    n_xfer++;
    for (int i = 0; i < 60; i++) begin
      rd(8'h0C, st);
      if (st[0] === 1'b0) break;
    end
    chk({31'h0, st[0]}, 32'h0000_0000);
    rd(8'h10, r);
  endtask : xfer
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // --------------------------------
  // Clock, watchdog, sequence
  // --------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    wrap_up();
  end
  initial begin
    resetn    = 1'b0;
    cmd_addr  = 8'h00;
    cmd_wdata = 32'h0000_0000;
    cmd_write = 1'b0;
    cmd_read  = 1'b0;
    failures   = 0;
    n_compared = 0;
    void'($urandom(67));
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h08, d);
    chk(d, 32'h0000_0003);
    rd(8'h14, d);
    chk(d, 32'h0000_0000);
    // Full words written in one style, read back in the other
    for (int i = 0; i < 10; i++) begin
      a   = 19'($urandom_range(14)) << 2;
      v   = $urandom;
      sty = i[0];
      xfer(a, v, ctl(1'b0, 2'b00, sty, 1'b0), s, d);
      chk(s & 32'h0000_000E, 32'h0000_0002);
      xfer(a, 32'h0000_0000, ctl(1'b1, 2'b00, ~sty, 1'b0), s, d);
      chk(d, v);
    end
    // Lane style: address bits 1,0 and size pins pick lanes; strobe style: size code
    for (int i = 0; i < 16; i++) begin
      a   = 19'($urandom_range(14)) << 2;
      w   = $urandom;
      v   = $urandom;
      sty = ~i[0];
      en  = (i == 0) ? 4'b1110 : (i == 1) ? 4'b0101 : 4'($urandom);
      x   = sty ? merge(w, v, en) : merge(w, v, ~size_lanes(en[1:0], en[3:2]));
      xfer(a, w, ctl(1'b0, 2'b00, sty, 1'b0), s, d);
      xfer(a | 19'(en[3:2]), v, ctl(1'b0, en[1:0], sty, 1'b0), s, d);
      xfer(a, 32'h0000_0000, ctl(1'b1, 2'b00, sty, 1'b0), s, d);
      chk(d, x);
    end
    // Half width: byte strobes pick lanes, upper half of the word stays
    for (int i = 0; i < 4; i++) begin
      a  = 19'($urandom_range(14)) << 2;
      w  = $urandom;
      v  = $urandom;
      en = (i == 0) ? 4'b1100 : 4'($urandom) | 4'b1100;
      x  = merge(w, v, en);
      xfer(a, w, ctl(1'b0, 2'b00, i[0], 1'b0), s, d);
      xfer(a | 19'($urandom_range(1)), v, ctl(1'b0, en[1:0], i[0], 1'b1), s, d);
      xfer(a, $urandom, ctl(1'b1, 2'b00, i[0], 1'b1), s, d);
      chk(d, x & 32'h0000_FFFF);
      xfer(a, 32'h0000_0000, ctl(1'b1, 2'b00, i[0], 1'b0), s, d);
      chk(d, x);
    end
    // Unmapped access: fault in both styles, acknowledge only in lane style
    for (int i = 0; i < 2; i++) begin
      sty = i[0];
      a   = 19'($urandom) | 19'h0_0040;
      xfer(a, $urandom, ctl(1'b0, 2'b00, sty, 1'b0), s, d);
      chk(s & 32'h0000_000E, {28'h0, 2'b01, sty, 1'b0});
    end
    // Mid-run reset returns the command registers to their reset values (control reads 3) and clears the device's words
    xfer(19'h0_0018, 32'hA5A5_5A5A, ctl(1'b0, 2'b00, 1'b0, 1'b0), s, d);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h08, d);
    chk(d, 32'h0000_0003);
    xfer(19'h0_0018, 32'h0000_0000, ctl(1'b1, 2'b00, 1'b0, 1'b0), s, d);
    chk(d, 32'h0000_0000);
    xfer(19'h0_003C, 32'h0000_0000, ctl(1'b1, 2'b00, 1'b1, 1'b0), s, d);
    chk(d & 32'h0000_0030, 32'h0000_0010);
    chk(sw & 32'h0000_003F, 32'h0000_0010);
    chk(n_seen, n_xfer);
    wrap_up();
  end
endmodule : host_parallel_port_with_bus_modes_tb
